//--- rtl/pwr_regs_pkg.sv
// Constants, field layouts and carriers of the power, oscillator and supply register bank.
// Assumes a single 20 MHz clock and a plain strobe register port with 8-bit byte addresses.
//
// Functional notes
// (R1) Detector mask set blocks the high-supply detector reset output; clear lets it act.
// (R2) Detector enable bit turns the detector on or off; read-only bit shows activity.
// (R3) Inhibit clear lets regulator enter deep mode in low-power sleep; set keeps full power.
// (R4) Regulator trim flag clears on power-on, sets when trim loads; gates reload on resets.
// (R5) Software leaves the factory regulator trim value alone.
// (R6) Regulator running bit reads one while enabled; read-only, writes ignored.
// (R7) Regulator settled bit reads one only once enabled and settled; read-only.
// (R8) Regulator enable bit switches the regulator; power-on reset forces it to one.
// (R9) Output select field resets to the nominal core level code.
// (R10) Oscillator trim flag clears on power-on, sets on fuse load; then reload only after power-on.
// (R11) Oscillator trim is ten bits at 9:8 and 7:0, driven to the oscillator.
// (R12) Sampling mode measures every two to the power of exponent plus five slow ticks.
// (R13) Supply monitor active bit reads one while the monitor is enabled; read-only.
// (R14) Supply monitor lock bit makes the whole register read-only until reset.
// (R15) Supply monitor trim flag clears on reset and sets once its trim loads.
// (R16) Force bit clear limits sampling to deepest sleep modes; set samples always.
// (R17) Mode 0 and 3 off, 1 on with reset, 2 on without reset, others reserved.
// (R18) Temperature sensor enable bit switches the sensor, resets to zero.
// (R19) Fast oscillator enable bit starts or stops it, resets to zero.
// (R20) Backup words are 32-bit read/write and survive shutdown.
// (R21) Software waits for the backup interface ready flag to clear before writing backups.
// (R22) Regulator register lock clears only on power-on reset.
// (R23) Writes to a locked register are dropped silently and contents are kept.
// (R24) Read-only status is synchronised to the bus clock before software sees it.
package pwr_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets.
  localparam logic [7:0] OFF_VREG = 8'h00;
  localparam logic [7:0] OFF_SYSRC = 8'h04;
  localparam logic [7:0] OFF_SUPPLY = 8'h08;
  localparam logic [7:0] OFF_TEMP = 8'h0c;
  localparam logic [7:0] OFF_FASTRC = 8'h10;
  localparam logic [7:0] OFF_PCSTAT = 8'h14;
  localparam logic [7:0] OFF_BKP = 8'h20;
  // Regulator word fields.
  localparam int VR_LOCK = 31;
  localparam int VR_MASK = 20;
  localparam int VR_STATE = 19;
  localparam int VR_DET_EN = 18;
  localparam int VR_INHIBIT = 17;
  localparam int VR_TLOAD = 16;
  localparam int VR_TRIM_LSB = 8;
  localparam int VR_TRIM_W = 4;
  localparam int VR_ON = 7;
  localparam int VR_SETTLED = 6;
  localparam int VR_EN = 5;
  localparam int VR_SEL_LSB = 0;
  localparam int VR_SEL_W = 2;
  localparam logic [1:0] VR_SEL_NOMINAL = 2'h0;
  localparam logic VR_EN_RST = 1'b1;
  localparam logic VR_DET_EN_RST = 1'b0;
  // System oscillator word fields.
  localparam int RC_TLOAD = 16;
  localparam int RC_TRIM_W = 10;
  // Supply monitor word fields.
  localparam int SW_EXP_LSB = 24;
  localparam int SW_EXP_W = 4;
  localparam int SW_ACTIVE = 18;
  localparam int SW_LOCK = 17;
  localparam int SW_TLOAD = 16;
  localparam int SW_TRIM_LSB = 8;
  localparam int SW_TRIM_W = 4;
  localparam int SW_FORCE = 7;
  localparam int SW_MODE_W = 3;
  localparam logic [2:0] SW_MODE_RESET = 3'h1;
  localparam logic [2:0] SW_MODE_NORESET = 3'h2;
  // Sampling interval: 2**(exponent + base) slow ticks.
  localparam int SAMPLE_EXP_BASE = 5;
  localparam int SAMPLE_CNT_W = 20;
  // Single-bit enable of the simple config words and ready flag of the status word.
  localparam int CFG_EN = 0;
  localparam int PC_BKP_READY = 0;

  typedef struct packed {
    logic lock;
    logic mask;
    logic det_en;
    logic inhibit;
    logic [VR_TRIM_W-1:0] trim;
    logic enable;
    logic [VR_SEL_W-1:0] sel;
  } vreg_t;

  typedef struct packed {
    logic [SW_EXP_W-1:0] exp;
    logic lock;
    logic [SW_TRIM_W-1:0] trim;
    logic force_smp;
    logic [SW_MODE_W-1:0] mode;
  } supply_t;

  typedef struct packed {
    logic reg_on;
    logic reg_settled;
    logic hsd_active;
    logic sm_active;
    logic bkp_ready;
  } ana_t;
endpackage

//--- rtl/backup_word_mem.sv
// Retained backup words and the registered read-data port of the register bank.
// Assumes por_n is asserted only by a power-on reset; shutdown keeps the array.
`timescale 1ns/10ps
module backup_word_mem #(
  parameter int WORDS = 4,
  parameter int IDX_W = 2
) (
  // Clock and resets.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic por_n,
  // Write side.
  input wire logic we,
  input wire logic [IDX_W-1:0] widx,
  input wire logic [31:0] wdata,
  // Read side.
  input wire logic re,
  input wire logic rsel,
  input wire logic [IDX_W-1:0] ridx,
  input wire logic [31:0] alt_data,
  output logic [31:0] rdata
);
  logic [31:0] mem_r [WORDS];
  logic [31:0] rdata_r;

  // Only a power-on reset clears the words, so they survive shutdown.
  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= 32'h0;
      end
    end else if (we) begin
      mem_r[widx] <= wdata; // R20
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (re) begin
      rdata_r <= rsel ? mem_r[ridx] : alt_data;
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign rdata = rdata_r;
endmodule

//--- rtl/power_osc_supply_ctrl_regs.sv
// Register bank for regulator, oscillator trims, supply monitor and backup words.
// Assumes synchronous side inputs; por_n low also holds rst_n low.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module power_osc_supply_ctrl_regs #(
  parameter int BKP_WORDS = 4,
  parameter int BKP_IDX_W = 2
) (
  // Clock and resets.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic por_n,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Fuse trim loading.
  output logic fuse_load_req,
  input wire logic fuse_valid,
  input wire logic [3:0] fuse_vreg_trim,
  input wire logic [9:0] fuse_sysrc_trim,
  input wire logic [3:0] fuse_supply_trim,
  // Analog status and events.
  input wire pwr_regs_pkg::ana_t ana_status,
  input wire logic hsd_trip,
  input wire logic sm_trip,
  input wire logic lf_tick,
  input wire logic sleep_low_power,
  input wire logic sleep_deep_static,
  // Controls to the analog blocks.
  output logic hsd_enable,
  output logic hsd_reset_out,
  output logic reg_enable,
  output logic reg_deep_mode,
  output logic [1:0] reg_out_sel,
  output logic [3:0] reg_trim,
  output logic [9:0] sysrc_trim,
  output logic [3:0] sm_trim,
  output logic sm_enable,
  output logic sm_reset_out,
  output logic sm_irq_req,
  output logic sm_sample,
  output logic temp_sensor_en,
  output logic fast_rc_en
);
  typedef enum logic {CAL_WAIT, CAL_DONE} cal_state_t;

  pwr_regs_pkg::vreg_t vreg_r;
  pwr_regs_pkg::supply_t sup_r;
  pwr_regs_pkg::ana_t sync1_r;
  pwr_regs_pkg::ana_t sync2_r;
  cal_state_t cal_r;
  logic vreg_tload_r;
  logic rc_tload_r;
  logic sm_tload_r;
  logic [9:0] rc_trim_r;
  logic temp_en_r;
  logic fast_en_r;
  logic fuse_req_r;
  logic [pwr_regs_pkg::SAMPLE_CNT_W-1:0] smp_cnt_r;
  logic smp_r;
  logic hsd_rst_r;
  logic deep_r;
  logic sm_rst_r;
  logic sm_irq_r;
  logic sm_en_r;
  logic [31:0] rd_word;
  logic fuse_load;
  logic wr_vreg;
  logic wr_sup;
  logic sm_on;
  logic smp_active;

  function automatic logic bkp_hit(input logic [7:0] a);
    int w;
    int b;
    w = int'(a[7:2]);
    b = int'(pwr_regs_pkg::OFF_BKP[7:2]);
    bkp_hit = (w >= b) && (w < b + BKP_WORDS);
  endfunction

  function automatic logic mode_on(input logic [2:0] m);
    mode_on = (m == pwr_regs_pkg::SW_MODE_RESET) || (m == pwr_regs_pkg::SW_MODE_NORESET);
  endfunction

  function automatic logic [pwr_regs_pkg::SAMPLE_CNT_W-1:0] smp_limit(input logic [3:0] e);
    logic [pwr_regs_pkg::SAMPLE_CNT_W:0] one;
    one = {{pwr_regs_pkg::SAMPLE_CNT_W{1'b0}}, 1'b1};
    smp_limit = pwr_regs_pkg::SAMPLE_CNT_W'((one << (int'(e) + pwr_regs_pkg::SAMPLE_EXP_BASE))
      - one);
  endfunction

  assign fuse_load = (cal_r == CAL_WAIT) && fuse_valid;
  assign wr_vreg = wr_en && (addr == pwr_regs_pkg::OFF_VREG) && !vreg_r.lock; // R23
  assign wr_sup = wr_en && (addr == pwr_regs_pkg::OFF_SUPPLY) && !sup_r.lock; // R23
  assign sm_on = mode_on(sup_r.mode);
  assign smp_active = sm_on && (sup_r.force_smp || sleep_deep_static);

  ////////////////////////////////////////////////////////////////////////////////
  // Status synchroniser: only the second stage is ever looked at.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= ana_status;
      sync2_r <= sync1_r; // R24
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trim loading after every reset; retained flags decide whether the regulator and oscillator trims take the fuse value, the supply trim always does.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_r <= CAL_WAIT;
      fuse_req_r <= 1'b1;
    end else begin
      case (cal_r)
        CAL_WAIT: begin
          if (fuse_valid) begin
            cal_r <= CAL_DONE;
            fuse_req_r <= 1'b0;
          end
        end
        CAL_DONE: begin
          fuse_req_r <= 1'b0;
        end
        default: begin
          cal_r <= CAL_WAIT;
          fuse_req_r <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Regulator word: retained across all but power-on reset.
  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      vreg_r.lock <= 1'b0; // R22
      vreg_r.mask <= 1'b0;
      vreg_r.det_en <= pwr_regs_pkg::VR_DET_EN_RST;
      vreg_r.inhibit <= 1'b0;
      vreg_r.trim <= '0;
      vreg_r.enable <= pwr_regs_pkg::VR_EN_RST; // R8
      vreg_r.sel <= pwr_regs_pkg::VR_SEL_NOMINAL; // R9
    end else begin
      if (wr_vreg) begin
        vreg_r.lock <= wdata[pwr_regs_pkg::VR_LOCK];
        vreg_r.mask <= wdata[pwr_regs_pkg::VR_MASK];
        vreg_r.det_en <= wdata[pwr_regs_pkg::VR_DET_EN]; // R2
        vreg_r.inhibit <= wdata[pwr_regs_pkg::VR_INHIBIT];
        vreg_r.trim <= wdata[pwr_regs_pkg::VR_TRIM_LSB +: pwr_regs_pkg::VR_TRIM_W];
        vreg_r.enable <= wdata[pwr_regs_pkg::VR_EN]; // R8
        vreg_r.sel <= wdata[pwr_regs_pkg::VR_SEL_LSB +: pwr_regs_pkg::VR_SEL_W];
      end
      if (fuse_load && !vreg_tload_r) begin
        vreg_r.trim <= fuse_vreg_trim; // R4
      end
    end
  end

  // Calibration flags that survive ordinary resets.
  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      vreg_tload_r <= 1'b0;
      rc_tload_r <= 1'b0;
    end else if (fuse_load) begin
      vreg_tload_r <= 1'b1; // R4
      rc_tload_r <= 1'b1; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System oscillator trim: software writes it, the fuses load it while the flag is clear.
  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      rc_trim_r <= 10'h0;
    end else if (fuse_load && !rc_tload_r) begin
      rc_trim_r <= fuse_sysrc_trim; // R10
    end else if (wr_en && (addr == pwr_regs_pkg::OFF_SYSRC)) begin
      rc_trim_r <= wdata[pwr_regs_pkg::RC_TRIM_W-1:0]; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Supply monitor word: the lock blocks software writes to every field until reset; a fuse load still sets the trim.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_r <= '0; // R14
    end else begin
      if (wr_sup) begin
        sup_r.exp <= wdata[pwr_regs_pkg::SW_EXP_LSB +: pwr_regs_pkg::SW_EXP_W];
        sup_r.lock <= wdata[pwr_regs_pkg::SW_LOCK]; // R14
        sup_r.trim <= wdata[pwr_regs_pkg::SW_TRIM_LSB +: pwr_regs_pkg::SW_TRIM_W];
        sup_r.force_smp <= wdata[pwr_regs_pkg::SW_FORCE];
        sup_r.mode <= wdata[pwr_regs_pkg::SW_MODE_W-1:0];
      end
      if (fuse_load) begin
        sup_r.trim <= fuse_supply_trim; // R15
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sm_tload_r <= 1'b0;
    end else if (fuse_load) begin
      sm_tload_r <= 1'b1; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Simple enables.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_en_r <= 1'b0;
      fast_en_r <= 1'b0;
    end else if (wr_en) begin
      if (addr == pwr_regs_pkg::OFF_TEMP) begin
        temp_en_r <= wdata[pwr_regs_pkg::CFG_EN]; // R18
      end
      if (addr == pwr_regs_pkg::OFF_FASTRC) begin
        fast_en_r <= wdata[pwr_regs_pkg::CFG_EN]; // R19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sampling timer on the slow tick; restarts whenever sampling stops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_cnt_r <= '0;
      smp_r <= 1'b0;
    end else if (!smp_active) begin
      smp_cnt_r <= '0; // R16
      smp_r <= 1'b0;
    end else if (lf_tick && (smp_cnt_r >= smp_limit(sup_r.exp))) begin
      smp_cnt_r <= '0;
      smp_r <= 1'b1; // R12
    end else begin
      smp_cnt_r <= lf_tick ? smp_cnt_r + 1'b1 : smp_cnt_r;
      smp_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Detector, regulator mode and monitor event outputs.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hsd_rst_r <= 1'b0;
      deep_r <= 1'b0;
      sm_rst_r <= 1'b0;
      sm_irq_r <= 1'b0;
      sm_en_r <= 1'b0;
    end else begin
      hsd_rst_r <= hsd_trip && vreg_r.det_en && !vreg_r.mask; // R1
      deep_r <= sleep_low_power && !vreg_r.inhibit; // R3
      sm_rst_r <= sm_trip && (sup_r.mode == pwr_regs_pkg::SW_MODE_RESET); // R17
      sm_irq_r <= sm_trip && sm_on; // R17
      sm_en_r <= sm_on; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read word assembly; reserved bits read as zero.
  always_comb begin
    rd_word = 32'h0;
    case (addr)
      pwr_regs_pkg::OFF_VREG: begin
        rd_word[pwr_regs_pkg::VR_LOCK] = vreg_r.lock;
        rd_word[pwr_regs_pkg::VR_MASK] = vreg_r.mask;
        rd_word[pwr_regs_pkg::VR_STATE] = sync2_r.hsd_active; // R2
        rd_word[pwr_regs_pkg::VR_DET_EN] = vreg_r.det_en;
        rd_word[pwr_regs_pkg::VR_INHIBIT] = vreg_r.inhibit;
        rd_word[pwr_regs_pkg::VR_TLOAD] = vreg_tload_r;
        rd_word[pwr_regs_pkg::VR_TRIM_LSB +: pwr_regs_pkg::VR_TRIM_W] = vreg_r.trim;
        rd_word[pwr_regs_pkg::VR_ON] = sync2_r.reg_on; // R6
        rd_word[pwr_regs_pkg::VR_SETTLED] = sync2_r.reg_settled && sync2_r.reg_on; // R7
        rd_word[pwr_regs_pkg::VR_EN] = vreg_r.enable;
        rd_word[pwr_regs_pkg::VR_SEL_LSB +: pwr_regs_pkg::VR_SEL_W] = vreg_r.sel;
      end
      pwr_regs_pkg::OFF_SYSRC: begin
        rd_word[pwr_regs_pkg::RC_TLOAD] = rc_tload_r;
        rd_word[pwr_regs_pkg::RC_TRIM_W-1:0] = rc_trim_r; // R11
      end
      pwr_regs_pkg::OFF_SUPPLY: begin
        rd_word[pwr_regs_pkg::SW_EXP_LSB +: pwr_regs_pkg::SW_EXP_W] = sup_r.exp;
        rd_word[pwr_regs_pkg::SW_ACTIVE] = sync2_r.sm_active; // R13
        rd_word[pwr_regs_pkg::SW_LOCK] = sup_r.lock;
        rd_word[pwr_regs_pkg::SW_TLOAD] = sm_tload_r;
        rd_word[pwr_regs_pkg::SW_TRIM_LSB +: pwr_regs_pkg::SW_TRIM_W] = sup_r.trim;
        rd_word[pwr_regs_pkg::SW_FORCE] = sup_r.force_smp;
        rd_word[pwr_regs_pkg::SW_MODE_W-1:0] = sup_r.mode;
      end
      pwr_regs_pkg::OFF_TEMP: rd_word[pwr_regs_pkg::CFG_EN] = temp_en_r;
      pwr_regs_pkg::OFF_FASTRC: rd_word[pwr_regs_pkg::CFG_EN] = fast_en_r;
      pwr_regs_pkg::OFF_PCSTAT: rd_word[pwr_regs_pkg::PC_BKP_READY] = sync2_r.bkp_ready;
      default: rd_word = 32'h0;
    endcase
  end

  // The memory holds the read-data flop, so every answer leaves from one register.
  backup_word_mem #(
    .WORDS(BKP_WORDS),
    .IDX_W(BKP_IDX_W)
  ) u_bkp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .por_n(por_n),
    .we(wr_en && bkp_hit(addr)),
    .widx(addr[2 +: BKP_IDX_W]),
    .wdata(wdata),
    .re(rd_en),
    .rsel(bkp_hit(addr)),
    .ridx(addr[2 +: BKP_IDX_W]),
    .alt_data(rd_word),
    .rdata(rdata)
  );

  assign fuse_load_req = fuse_req_r;
  assign hsd_enable = vreg_r.det_en;
  assign hsd_reset_out = hsd_rst_r;
  assign reg_enable = vreg_r.enable;
  assign reg_deep_mode = deep_r;
  assign reg_out_sel = vreg_r.sel;
  assign reg_trim = vreg_r.trim;
  assign sysrc_trim = rc_trim_r;
  assign sm_trim = sup_r.trim;
  assign sm_enable = sm_en_r;
  assign sm_reset_out = sm_rst_r;
  assign sm_irq_req = sm_irq_r;
  assign sm_sample = smp_r;
  assign temp_sensor_en = temp_en_r;
  assign fast_rc_en = fast_en_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_mask_blocks;
    @(posedge sys_clk) disable iff (!rst_n)
    (vreg_r.mask || !vreg_r.det_en) |=> !hsd_reset_out;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked detector reset fired"); // R1

  property p_deep_mode;
    @(posedge sys_clk) disable iff (!rst_n)
    vreg_r.inhibit |=> !reg_deep_mode;
  endproperty
  a_deep_mode: assert property (p_deep_mode) else $error("deep mode while inhibited"); // R3

  property p_trim_flag;
    @(posedge sys_clk) disable iff (!por_n)
    $rose(vreg_tload_r) |-> $past(fuse_valid);
  endproperty
  a_trim_flag: assert property (p_trim_flag) else $error("trim flag set without fuse"); // R4

  property p_settled_read;
    @(posedge sys_clk) disable iff (!rst_n)
    (rd_en && addr == pwr_regs_pkg::OFF_VREG)
      |=> !(rdata[pwr_regs_pkg::VR_SETTLED] && !rdata[pwr_regs_pkg::VR_ON]);
  endproperty
  a_settled_read: assert property (p_settled_read) else $error("settled while off"); // R7

  property p_sample_cause;
    @(posedge sys_clk) disable iff (!rst_n)
    sm_sample |-> $past(lf_tick) && $past(smp_active);
  endproperty
  a_sample_cause: assert property (p_sample_cause) else $error("sample without tick"); // R12

  property p_lock_holds;
    @(posedge sys_clk) disable iff (!rst_n)
    (sup_r.lock && wr_en && addr == pwr_regs_pkg::OFF_SUPPLY && !fuse_valid) |=> $stable(sup_r);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked word changed"); // R14

  property p_vlock_keep;
    @(posedge sys_clk) disable iff (!por_n)
    vreg_r.lock |=> vreg_r.lock;
  endproperty
  a_vlock_keep: assert property (p_vlock_keep) else $error("regulator lock dropped"); // R22

  property p_sm_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    sm_reset_out |-> $past(sup_r.mode) == pwr_regs_pkg::SW_MODE_RESET && $past(sm_trip);
  endproperty
  a_sm_reset: assert property (p_sm_reset) else $error("monitor reset in wrong mode"); // R17

  property p_status_sync;
    @(posedge sys_clk) disable iff (!rst_n)
    (rd_en && addr == pwr_regs_pkg::OFF_SUPPLY) ##1 $past(rst_n, 3)
      |-> rdata[pwr_regs_pkg::SW_ACTIVE] == $past(ana_status.sm_active, 3);
  endproperty
  a_status_sync: assert property (p_status_sync) else $error("status not two flops late"); // R24

  property p_temp_en;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_en && addr == pwr_regs_pkg::OFF_TEMP) |=> temp_sensor_en == $past(wdata[0]);
  endproperty
  a_temp_en: assert property (p_temp_en) else $error("temperature enable not taken"); // R18
endmodule

//--- dv/power_osc_supply_ctrl_regs_tb_top.sv
// Self-checking bench for the power, oscillator and supply register bank.
// Assumes the bench alone drives every port; 20 MHz clock, strobe register port.
`timescale 1ns/10ps
module power_osc_supply_ctrl_regs_tb_top;
  logic sys_clk, rst_n, por_n, wr_en, rd_en, fuse_valid, hsd_trip, sm_trip, lf_tick;
  logic slp_lp, slp_ds, fuse_load_req, hsd_enable, hsd_reset_out, reg_enable, reg_deep_mode;
  logic sm_enable, sm_reset_out, sm_irq_req, sm_sample, temp_sensor_en, fast_rc_en;
  logic [1:0] reg_out_sel;
  logic [3:0] fvt, fst, reg_trim, sm_trim;
  logic [9:0] frt, sysrc_trim;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv, seed;
  pwr_regs_pkg::ana_t ana;
  int error_cnt, num_checks, cyc, smp_cnt;
  logic [31:0] bq[$];
  //////////////////////////////////////////////////////////////////////////////
  power_osc_supply_ctrl_regs DUT (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .fuse_load_req(fuse_load_req), .fuse_valid(fuse_valid), .fuse_vreg_trim(fvt),
    .fuse_sysrc_trim(frt), .fuse_supply_trim(fst), .ana_status(ana), .hsd_trip(hsd_trip),
    .sm_trip(sm_trip), .lf_tick(lf_tick), .sleep_low_power(slp_lp),
    .sleep_deep_static(slp_ds), .hsd_enable(hsd_enable), .hsd_reset_out(hsd_reset_out),
    .reg_enable(reg_enable), .reg_deep_mode(reg_deep_mode), .reg_out_sel(reg_out_sel),
    .reg_trim(reg_trim), .sysrc_trim(sysrc_trim), .sm_trim(sm_trim), .sm_enable(sm_enable),
    .sm_reset_out(sm_reset_out), .sm_irq_req(sm_irq_req), .sm_sample(sm_sample),
    .temp_sensor_en(temp_sensor_en), .fast_rc_en(fast_rc_en));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask
  task automatic do_rst(input logic por);
    rst_n <= 1'b0;
    if (por) por_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    // The status synchroniser reads zero until it has refilled after reset.
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic fuse(input logic [3:0] v, input logic [9:0] r, input logic [3:0] s);
    @(posedge sys_clk);
    fuse_valid <= 1'b1;
    fvt <= v;
    frt <= r;
    fst <= s;
    @(posedge sys_clk);
    fuse_valid <= 1'b0;
    #1;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      lf_tick <= 1'b1;
      @(posedge sys_clk);
      lf_tick <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask
  // A stuck design must still reach the verdict, so the run is capped.
  always @(posedge sys_clk) begin
    cyc++;
    if (sm_sample === 1'b1) smp_cnt++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, por_n, wr_en, rd_en, fuse_valid, hsd_trip, sm_trip, lf_tick, slp_lp, slp_ds} = '0;
    {fvt, fst, frt, addr, wdata} = '0;
    ana = '0;
    seed = 32'ha127b3ab;
    do_rst(1'b1);
    rchk("vreg_rst", pwr_regs_pkg::OFF_VREG, 32'h20);
    chk("fuse_req", fuse_load_req, 1);
    fuse(4'h5, 10'h2a5, 4'h9);
    chk("sysrc_trim", sysrc_trim, 10'h2a5);
    rchk("vreg_fuse", pwr_regs_pkg::OFF_VREG, 32'h10520);
    rchk("sysrc_fuse", pwr_regs_pkg::OFF_SYSRC, 32'h102a5);
    rchk("sup_fuse", pwr_regs_pkg::OFF_SUPPLY, 32'h10900);
    // Backup interface ready stays clear while backups are written.
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(pwr_regs_pkg::OFF_BKP + 8'(4 * i), seed);
      bq.push_back(seed);
    end
    do_rst(1'b0);
    fuse(4'ha, 10'h155, 4'h3);
    chk("reg_trim", reg_trim, 4'h5);
    chk("sysrc_keep", sysrc_trim, 10'h2a5);
    chk("sm_trim", sm_trim, 4'h3);
    for (int i = 0; i < 4; i++) rchk("bkp", pwr_regs_pkg::OFF_BKP + 8'(4 * i), bq[i]);
    rchk("unmapped", 8'h18, 32'h0);
    rchk("temp_rst", pwr_regs_pkg::OFF_TEMP, 32'h0);
    rchk("fast_rst", pwr_regs_pkg::OFF_FASTRC, 32'h0);
    wr(pwr_regs_pkg::OFF_TEMP, 32'h1);
    chk("temp_on", temp_sensor_en, 1);
    wr(pwr_regs_pkg::OFF_FASTRC, 32'h1);
    chk("fast_on", fast_rc_en, 1);
    wr(pwr_regs_pkg::OFF_FASTRC, 32'h0);
    chk("fast_off", fast_rc_en, 0);
    ana <= 5'b10000;
    slp_lp <= 1'b1;
    hsd_trip <= 1'b1;
    wr(pwr_regs_pkg::OFF_VREG, 32'h000d05e3);
    rchk("vreg_ro", pwr_regs_pkg::OFF_VREG, 32'h000505a3);
    chk("det_en", hsd_enable, 1);
    chk("out_sel", reg_out_sel, 2'h3);
    chk("deep", reg_deep_mode, 1);
    chk("hsd_rst", hsd_reset_out, 1);
    wr(pwr_regs_pkg::OFF_VREG, 32'h001705a3);
    @(posedge sys_clk);
    #1 chk("deep_inh", reg_deep_mode, 0);
    chk("hsd_mask", hsd_reset_out, 0);
    wr(pwr_regs_pkg::OFF_VREG, 32'h801705a3);
    wr(pwr_regs_pkg::OFF_VREG, 32'h0);
    chk("reg_en", reg_enable, 1);
    do_rst(1'b0);
    rchk("vreg_lock", pwr_regs_pkg::OFF_VREG, 32'h801705a3);
    sm_trip <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      wr(pwr_regs_pkg::OFF_SUPPLY, 32'(m));
      @(posedge sys_clk);
      #1 chk("sm_en", sm_enable, (m == 1 || m == 2));
      chk("sm_rst", sm_reset_out, (m == 1));
      chk("sm_irq", sm_irq_req, (m == 1 || m == 2));
    end
    ana <= 5'b10010;
    wr(pwr_regs_pkg::OFF_SUPPLY, 32'h2);
    smp_cnt = 0;
    ticks(64);
    chk("smp_idle", smp_cnt, 0);
    rchk("sm_act", pwr_regs_pkg::OFF_SUPPLY, 32'h00040002);
    slp_ds <= 1'b1;
    ticks(64);
    chk("smp_ds", smp_cnt, 2);
    slp_ds <= 1'b0;
    wr(pwr_regs_pkg::OFF_SUPPLY, 32'h00020082);
    smp_cnt = 0;
    ticks(64);
    chk("smp_force", smp_cnt, 2);
    wr(pwr_regs_pkg::OFF_SUPPLY, 32'h0);
    chk("sm_locked", sm_enable, 1);
    do_rst(1'b0);
    rchk("sm_unlock", pwr_regs_pkg::OFF_SUPPLY, 32'h00040000);
    do_rst(1'b1);
    rchk("vreg_por", pwr_regs_pkg::OFF_VREG, 32'ha0);
    close_out();
  end
endmodule
